/* rtl/boost_supply_supervisor.sv */
// boost converter switch control and pre-driver supply undervoltage supervision
//
// Summary of operation
// - filtered pre-driver supply low forces every gate driver output off.
// - drivers return only after supply good and the glitch filter delay elapsed.
// - supply low sets a sticky flag; with enable it pulls the interrupt pin low.
// - no boosting in reset or without adequate battery supply.
// - low enable pin stops boosting only when override bit is zero; override resets one.
// - eight-bit threshold word from the voltage DAC register feeds the boost comparator.
// - boost comparator filter length and type come from the filter register.
// - low and high five-bit current levels regulate switch current in hardware in variable mode only.
// - negative current level flags capacitor overcurrent in variable-frequency mode only.
// - both modes start below the voltage window and stop above it.
// - variable mode: switch on below low current, off above high current.
// - variable mode suspends switching during injection phases.
// - burst start loads upper threshold and waits for comparator filter first.
// - above upper threshold: switch off, lower threshold, settle, then wait low.
// - fixed mode keeps switching through injection with fixed on and off times.
// - fixed mode loads upper threshold, settles, and stops at upper threshold.
// - switch low on enable negated without override, any supply low, clock fault or channel low.
`timescale 1ns/10ps
`default_nettype none
`include "boost_supervisor_defines.svh"

module boost_supply_supervisor #(
	parameter int FILT_W = 10,
	parameter int SUPPLY_FILTER_CYCLES = `SUPPLY_FILTER_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire boost_supervisor_pkg::reg_req_t regReq,
	output logic [`DATA_W-1:0] regRdData,
	input wire logic supplyCompLow,
	input wire boost_supervisor_pkg::supply_status_t supplyStatus,
	input wire boost_supervisor_pkg::loop_sense_t loopSense,
	output logic gateDriversOff,
	output logic boostSwitchDriver,
	output logic [7:0] comparatorThreshold,
	output logic [4:0] currentLowLevel,
	output logic [4:0] currentHighLevel,
	output logic [4:0] negativeCurrentLevel,
	output logic interruptRequestPinN
);
	import boost_supervisor_pkg::*;

	// refuse parameters the counters cannot hold
	if (FILT_W < 2 || FILT_W > 15) begin : g_bad_width
		$error("filter counter width out of range");
	end
	if (SUPPLY_FILTER_CYCLES < 1 || SUPPLY_FILTER_CYCLES >= (1 << FILT_W)) begin : g_bad_count
		$error("supply filter count does not fit the counter");
	end

	function automatic logic addrIs(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
		addrIs = (a == ofs);
	endfunction : addrIs

	logic [`DATA_W-1:0] dac_reg;
	logic [`DATA_W-1:0] filtCfg_reg;
	logic [`DATA_W-1:0] cfg_reg;
	logic [`DATA_W-1:0] curLvl_reg;
	logic [`DATA_W-1:0] fixTime_reg;
	logic [`DATA_W-1:0] rdData_reg;
	logic supplyFlag_reg;
	logic negFlag_reg;
	logic irqN_reg;
	logic switch_reg;
	logic switch_next;
	logic loopOn_reg;
	logic [7:0] phaseTimer_reg;
	logic [7:0] threshold_reg;
	burst_state_t state_reg;
	burst_state_t state_next;
	logic supplyLow;
	logic boostAboveFilt;
	logic boostSettled;
	logic boostAllowed;
	logic fixedMode;
	logic faultRead;
	logic [FILT_W-1:0] supplyLen;
	logic [FILT_W-1:0] boostLen;

	assign fixedMode = cfg_reg[`CFG_FIXED_BIT];
	assign faultRead = regReq.read && addrIs(regReq.addr, `OFS_DRIVER_FAULT_FLAGS);
	assign supplyLen = FILT_W'(SUPPLY_FILTER_CYCLES);
	assign boostLen = filtCfg_reg[`FILT_LEN_LSB +: FILT_W];

	// supply low asserts at once, releases only after a quiet filter period
	comparator_glitch_filter #(
		.FILT_W(FILT_W),
		.RST_LEVEL(1'b1)
	) u_supply_filter (
		.clock(clock),
		.nrst(nrst),
		.rawIn(supplyCompLow),
		.restart(1'b0),
		.assertFast(1'b1),
		.length(supplyLen),
		.filtered(supplyLow),
		.settled()
	);

	// threshold changes restart the boost filter so the comparator is judged fresh
	comparator_glitch_filter #(
		.FILT_W(FILT_W),
		.RST_LEVEL(1'b0)
	) u_boost_filter (
		.clock(clock),
		.nrst(nrst),
		.rawIn(loopSense.boostAbove),
		.restart(state_reg == ST_LOAD_HIGH || state_reg == ST_LOAD_LOW),
		.assertFast(filtCfg_reg[`FILT_TYPE_BIT]),
		.length(boostLen),
		.filtered(boostAboveFilt),
		.settled(boostSettled)
	);

	// register writes
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dac_reg <= `RST_BOOST_VOLTAGE_DAC;
			filtCfg_reg <= `RST_BOOST_FILTER_CFG;
			cfg_reg <= `RST_DRIVER_CONFIGURATION;
			curLvl_reg <= `RST_CURRENT_LEVELS;
			fixTime_reg <= `RST_FIXED_TIMING;
		end else if (regReq.write) begin
			if (addrIs(regReq.addr, `OFS_BOOST_VOLTAGE_DAC)) begin
				dac_reg <= regReq.wrData;
			end
			if (addrIs(regReq.addr, `OFS_BOOST_FILTER_CFG)) begin
				filtCfg_reg <= regReq.wrData;
			end
			if (addrIs(regReq.addr, `OFS_DRIVER_CONFIGURATION)) begin
				cfg_reg <= regReq.wrData;
			end
			if (addrIs(regReq.addr, `OFS_CURRENT_LEVELS)) begin
				curLvl_reg <= regReq.wrData;
			end
			if (addrIs(regReq.addr, `OFS_FIXED_TIMING)) begin
				fixTime_reg <= regReq.wrData;
			end
		end
	end

	// register reads, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdData_reg <= 16'h0000;
		end else if (regReq.read) begin
			unique case (1'b1)
				addrIs(regReq.addr, `OFS_BOOST_VOLTAGE_DAC): rdData_reg <= dac_reg;
				addrIs(regReq.addr, `OFS_BOOST_FILTER_CFG): rdData_reg <= filtCfg_reg;
				addrIs(regReq.addr, `OFS_DRIVER_CONFIGURATION): rdData_reg <= cfg_reg;
				addrIs(regReq.addr, `OFS_CURRENT_LEVELS): rdData_reg <= {1'b0, curLvl_reg[14:0]};
				addrIs(regReq.addr, `OFS_FIXED_TIMING): rdData_reg <= fixTime_reg;
				addrIs(regReq.addr, `OFS_DRIVER_FAULT_FLAGS): rdData_reg <= {12'h000, switch_reg,
					supplyLow, negFlag_reg, supplyFlag_reg};
				default: rdData_reg <= 16'h0000;
			endcase
		end
	end

	// sticky flags cleared by reading; a set in the same cycle wins
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			supplyFlag_reg <= 1'b0;
			negFlag_reg <= 1'b0;
		end else begin
			supplyFlag_reg <= supplyLow | (supplyFlag_reg & ~faultRead);
			negFlag_reg <= (loopSense.currentNegOver & ~fixedMode) | (negFlag_reg & ~faultRead);
		end
	end

	// interrupt pin pulled low while the flag stands and is enabled
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irqN_reg <= 1'b1;
		end else begin
			irqN_reg <= ~(supplyFlag_reg & cfg_reg[`CFG_IRQ_EN_BIT]);
		end
	end

	// every gating condition of the switch except the channel switch request in one term
	assign boostAllowed = supplyStatus.batterySupplyOk
		& (cfg_reg[`CFG_OVERRIDE_BIT] | supplyStatus.driverEnablePin)
		& ~supplyLow & ~supplyStatus.logicSupplyLowFlag & supplyStatus.clockDriveOk
		& cfg_reg[`CFG_RUN_BIT];

	// burst sequencer: wait low, raise threshold, settle, switch, lower, settle
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: state_next = ST_WAIT_LOW;
			ST_WAIT_LOW: begin
				if (boostSettled && !boostAboveFilt) begin
					state_next = ST_LOAD_HIGH;
				end
			end
			ST_LOAD_HIGH: state_next = ST_SETTLE_HIGH;
			ST_SETTLE_HIGH: begin
				if (boostSettled) begin
					state_next = ST_SWITCHING;
				end
			end
			ST_SWITCHING: begin
				if (boostAboveFilt) begin
					state_next = ST_LOAD_LOW;
				end
			end
			ST_LOAD_LOW: state_next = ST_SETTLE_LOW;
			ST_SETTLE_LOW: begin
				if (boostSettled) begin
					state_next = ST_WAIT_LOW;
				end
			end
			default: state_next = ST_IDLE;
		endcase
		if (!boostAllowed) begin
			state_next = ST_IDLE;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// comparator threshold: upper during a burst, lower otherwise
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			threshold_reg <= 8'h00;
		end else if (state_next == ST_LOAD_HIGH) begin
			threshold_reg <= dac_reg[`DAC_UPPER_LSB +: 8];
		end else if (state_next == ST_LOAD_LOW || state_next == ST_IDLE || state_next == ST_WAIT_LOW) begin
			threshold_reg <= dac_reg[`DAC_LOWER_LSB +: 8];
		end
	end

	// current loop: comparator hysteresis in variable mode, timed phases in fixed mode
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			loopOn_reg <= 1'b0;
			phaseTimer_reg <= 8'h00;
		end else if (state_reg != ST_SWITCHING) begin
			loopOn_reg <= 1'b0;
			phaseTimer_reg <= 8'h00;
		end else if (fixedMode) begin
			if (phaseTimer_reg == 8'h00) begin
				loopOn_reg <= ~loopOn_reg;
				phaseTimer_reg <= loopOn_reg ? fixTime_reg[`FIX_OFF_LSB +: 8] : fixTime_reg[`FIX_ON_LSB +: 8];
			end else begin
				phaseTimer_reg <= phaseTimer_reg - 8'h01;
			end
		end else if (loopSense.currentAboveHigh) begin
			loopOn_reg <= 1'b0;
		end else if (loopSense.currentBelowLow) begin
			loopOn_reg <= 1'b1;
		end
	end

	// switch command; injection blanks only the variable-frequency loop
	assign switch_next = boostAllowed & supplyStatus.channelSwitchRequest
		& (state_reg == ST_SWITCHING) & ~boostAboveFilt & loopOn_reg
		& (fixedMode | ~loopSense.injectionActive);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			switch_reg <= 1'b0;
		end else begin
			switch_reg <= switch_next;
		end
	end

	assign regRdData = rdData_reg;
	assign gateDriversOff = supplyLow;
	assign boostSwitchDriver = switch_reg;
	assign comparatorThreshold = threshold_reg;
	assign currentLowLevel = curLvl_reg[`CUR_LOW_LSB +: 5];
	assign currentHighLevel = curLvl_reg[`CUR_HIGH_LSB +: 5];
	assign negativeCurrentLevel = curLvl_reg[`CUR_NEG_LSB +: 5];
	assign interruptRequestPinN = irqN_reg;

	// helper: consecutive cycles of good supply, saturating
	logic [FILT_W:0] goodRun_reg;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			goodRun_reg <= '0;
		end else if (supplyCompLow) begin
			goodRun_reg <= '0;
		end else if (goodRun_reg[FILT_W] == 1'b0) begin
			goodRun_reg <= goodRun_reg + 1'b1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	property p_supply_low_off;
		supplyCompLow |=> gateDriversOff ##1 !boostSwitchDriver;
	endproperty
	a_supply_low_off: assert property (p_supply_low_off) else $error("supply low did not stop drivers");

	property p_release_delay;
		$fell(gateDriversOff) |-> goodRun_reg >= (FILT_W+1)'(SUPPLY_FILTER_CYCLES);
	endproperty
	a_release_delay: assert property (p_release_delay) else $error("drivers released before filter delay");

	property p_irq;
		(gateDriversOff && cfg_reg[`CFG_IRQ_EN_BIT]) |=> ##1 !interruptRequestPinN;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt pin not pulled low");

	property p_battery;
		!supplyStatus.batterySupplyOk |=> !boostSwitchDriver;
	endproperty
	a_battery: assert property (p_battery) else $error("switch on with low battery");

	property p_enable_pin;
		(!supplyStatus.driverEnablePin && !cfg_reg[`CFG_OVERRIDE_BIT]) |=> !boostSwitchDriver;
	endproperty
	a_enable_pin: assert property (p_enable_pin) else $error("enable pin ignored without override");

	property p_gating;
		(supplyStatus.logicSupplyLowFlag || !supplyStatus.clockDriveOk || !supplyStatus.channelSwitchRequest)
			|=> !boostSwitchDriver;
	endproperty
	a_gating: assert property (p_gating) else $error("switch on despite gating condition");

	property p_var_turn_on;
		($rose(boostSwitchDriver) && !fixedMode) |-> $past(loopOn_reg) && !$past(loopSense.injectionActive);
	endproperty
	a_var_turn_on: assert property (p_var_turn_on) else $error("variable mode switch on without loop");

	property p_injection;
		(loopSense.injectionActive && !fixedMode) |=> !boostSwitchDriver;
	endproperty
	a_injection: assert property (p_injection) else $error("switching during injection");

	property p_burst_start;
		$rose(state_reg == ST_SWITCHING) |-> comparatorThreshold == dac_reg[`DAC_UPPER_LSB +: 8] && $past(boostSettled);
	endproperty
	a_burst_start: assert property (p_burst_start) else $error("burst began without upper threshold");

	property p_burst_end;
		(state_reg == ST_SWITCHING && boostAboveFilt && boostAllowed) |=> state_reg == ST_LOAD_LOW
			&& !boostSwitchDriver && comparatorThreshold == dac_reg[`DAC_LOWER_LSB +: 8];
	endproperty
	a_burst_end: assert property (p_burst_end) else $error("burst did not end at upper threshold");

	property p_neg_flag;
		(loopSense.currentNegOver && !fixedMode) |=> negFlag_reg;
	endproperty
	a_neg_flag: assert property (p_neg_flag) else $error("negative current not flagged");

endmodule : boost_supply_supervisor
`default_nettype wire

/* rtl/boost_supervisor_defines.svh */
// register map, field positions, reset values and timing counts of the boost supervisor
`ifndef BOOST_SUPERVISOR_DEFINES_SVH
`define BOOST_SUPERVISOR_DEFINES_SVH

`define ADDR_W 9
`define DATA_W 16

// register offsets
`define OFS_BOOST_VOLTAGE_DAC 9'h19B
`define OFS_BOOST_FILTER_CFG 9'h19D
`define OFS_DRIVER_CONFIGURATION 9'h1C5
`define OFS_CURRENT_LEVELS 9'h1C8
`define OFS_FIXED_TIMING 9'h1C9
`define OFS_DRIVER_FAULT_FLAGS 9'h1D2

// field positions
`define DAC_UPPER_LSB 0
`define DAC_LOWER_LSB 8
`define FILT_LEN_LSB 0
`define FILT_TYPE_BIT 15
`define CFG_OVERRIDE_BIT 0
`define CFG_IRQ_EN_BIT 1
`define CFG_FIXED_BIT 2
`define CFG_RUN_BIT 3
`define CUR_LOW_LSB 0
`define CUR_HIGH_LSB 5
`define CUR_NEG_LSB 10
`define FIX_ON_LSB 0
`define FIX_OFF_LSB 8
`define FLT_SUPPLY_LOW_BIT 0
`define FLT_NEG_CURRENT_BIT 1
`define FLT_SUPPLY_LIVE_BIT 2
`define FLT_SWITCH_BIT 3

// reset values
`define RST_BOOST_VOLTAGE_DAC 16'h0000
`define RST_BOOST_FILTER_CFG 16'h0010
`define RST_DRIVER_CONFIGURATION 16'h0001
`define RST_CURRENT_LEVELS 16'h0000
`define RST_FIXED_TIMING 16'h0808

// timing
`define CLK_MHZ 250
`define SUPPLY_FILTER_NS 1300
`define SUPPLY_FILTER_CYCLES ((`SUPPLY_FILTER_NS * `CLK_MHZ + 999) / 1000)

`endif

/* rtl/boost_supervisor_pkg.sv */
// types shared by the boost supervisor files
`include "boost_supervisor_defines.svh"

package boost_supervisor_pkg;

	// register access request from the microcore side
	typedef struct packed {
		logic write;
		logic read;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] wrData;
	} reg_req_t;

	// supply and enable conditions of the boost switch driver
	typedef struct packed {
		logic batterySupplyOk;
		logic logicSupplyLowFlag;
		logic clockDriveOk;
		logic driverEnablePin;
		logic channelSwitchRequest;
	} supply_status_t;

	// comparator outputs of the boost loop
	typedef struct packed {
		logic boostAbove;
		logic currentBelowLow;
		logic currentAboveHigh;
		logic currentNegOver;
		logic injectionActive;
	} loop_sense_t;

	// burst sequencer, gray along the usual path
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT_LOW = 3'h1,
		ST_LOAD_HIGH = 3'h3,
		ST_SETTLE_HIGH = 3'h2,
		ST_SWITCHING = 3'h6,
		ST_LOAD_LOW = 3'h7,
		ST_SETTLE_LOW = 3'h5
	} burst_state_t;

endpackage : boost_supervisor_pkg

/* rtl/comparator_glitch_filter.sv */
// restartable counter filter for a comparator output
`timescale 1ns/10ps
`default_nettype none

module comparator_glitch_filter #(
	parameter int FILT_W = 10,
	parameter logic RST_LEVEL = 1'b0
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic rawIn,
	input wire logic restart,
	input wire logic assertFast,
	input wire logic [FILT_W-1:0] length,
	output logic filtered,
	output logic settled
);

	logic prev_reg;
	logic [FILT_W-1:0] count_reg;
	logic filtered_reg;

	// count stable cycles; any toggle of the input starts over
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prev_reg <= 1'b0;
			count_reg <= '0;
		end else begin
			prev_reg <= rawIn;
			if (restart || rawIn != prev_reg) begin
				count_reg <= '0;
			end else if (count_reg < length) begin // saturate, even when length is lowered below the count
				count_reg <= count_reg + 1'b1;
			end
		end
	end

	// fast assertion skips the delay, so faults act at once
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			filtered_reg <= RST_LEVEL;
		end else if (assertFast && rawIn) begin
			filtered_reg <= 1'b1;
		end else if (count_reg >= length && rawIn == prev_reg && !restart) begin
			filtered_reg <= prev_reg;
		end
	end

	assign filtered = filtered_reg;
	assign settled = (count_reg >= length);

endmodule : comparator_glitch_filter
`default_nettype wire

/* testbench/boost_plant_model.sv */
// behavioural boost power stage: inductor current, output voltage and comparators
`timescale 1ns/10ps
`default_nettype none

module boost_plant_model (
	input wire logic clock,
	input wire logic nrst,
	input wire logic switchOn,
	input wire logic [7:0] threshold,
	input wire logic [4:0] lowLevel,
	input wire logic [4:0] highLevel,
	output logic boostAbove,
	output logic currentBelowLow,
	output logic currentAboveHigh
);
	logic [5:0] currentReg;
	logic [7:0] voltReg;
	logic [3:0] leakReg;

	// current ramps while on, decays while off; diode blocks reverse current
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			currentReg <= 6'h00;
		end else if (switchOn && currentReg != 6'h3F) begin
			currentReg <= currentReg + 6'h01;
		end else if (!switchOn && currentReg != 6'h00) begin
			currentReg <= currentReg - 6'h01;
		end
	end

	// output charges only while the inductor discharges; load leaks it slowly
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			voltReg <= 8'h00;
			leakReg <= 4'h0;
		end else begin
			leakReg <= leakReg + 4'h1;
			if (!switchOn && currentReg != 6'h00 && voltReg != 8'hFF) begin
				voltReg <= voltReg + 8'h01;
			end else if (leakReg == 4'hF && voltReg != 8'h00) begin
				voltReg <= voltReg - 8'h01;
			end
		end
	end

	// ideal comparators, no offset or delay
	assign boostAbove = voltReg > threshold;
	assign currentBelowLow = currentReg < {1'b0, lowLevel};
	assign currentAboveHigh = currentReg > {1'b0, highLevel};
endmodule : boost_plant_model
`default_nettype wire

/* testbench/boost_supply_supervisor_test.sv */
// self-checking bench for the boost supervisor and its supply monitor
`timescale 1ns/10ps
`default_nettype none
`include "boost_supervisor_defines.svh"

module boost_supply_supervisor_test;
	import boost_supervisor_pkg::*;
	localparam int FILT = 8;
	localparam int CYCLE_LIMIT = 40000;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	reg_req_t regReq = '0;
	logic [15:0] regRdData;
	logic supplyCompLow = 1'b0;
	supply_status_t supplyStatus = 5'b10111;
	loop_sense_t loopSense;
	logic negOver = 1'b0;
	logic inject = 1'b0;
	logic gateDriversOff, boostSwitchDriver, interruptRequestPinN, above, below, overHigh;
	logic [7:0] comparatorThreshold;
	logic [4:0] currentLowLevel, currentHighLevel, negativeCurrentLevel;
	logic [15:0] rd;
	int n_mismatch = 0;
	int total_checks = 0;
	int cycleCount = 0;
	int n;

	boost_supply_supervisor #(.FILT_W(10), .SUPPLY_FILTER_CYCLES(FILT)) dut_u (.clock(clock), .nrst(nrst),
		.regReq(regReq), .regRdData(regRdData), .supplyCompLow(supplyCompLow), .supplyStatus(supplyStatus),
		.loopSense(loopSense), .gateDriversOff(gateDriversOff), .boostSwitchDriver(boostSwitchDriver),
		.comparatorThreshold(comparatorThreshold), .currentLowLevel(currentLowLevel),
		.currentHighLevel(currentHighLevel), .negativeCurrentLevel(negativeCurrentLevel),
		.interruptRequestPinN(interruptRequestPinN));
	boost_plant_model plant_u (.clock(clock), .nrst(nrst), .switchOn(boostSwitchDriver),
		.threshold(comparatorThreshold), .lowLevel(currentLowLevel), .highLevel(currentHighLevel),
		.boostAbove(above), .currentBelowLow(below), .currentAboveHigh(overHigh));
	// negative current and injection come from the bench, the rest from the plant
	assign loopSense = '{above, below, overHigh, negOver, inject};

	// 250 MHz
	always #2 clock = ~clock;

	// hang guard
	always @(posedge clock) begin
		cycleCount <= cycleCount + 1;
		if (cycleCount == CYCLE_LIMIT) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	task automatic checkVal(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : checkVal

	task automatic regWrite(input logic [`ADDR_W-1:0] a, input logic [15:0] d);
		@(negedge clock);
		regReq = '{1'b1, 1'b0, a, d};
		@(negedge clock);
		regReq = '0;
	endtask : regWrite

	// read data is registered at the taking edge and sampled at the next falling edge
	task automatic regRead(input logic [`ADDR_W-1:0] a, output logic [15:0] d);
		@(negedge clock);
		regReq = '{1'b0, 1'b1, a, 16'h0000};
		@(negedge clock);
		d = regRdData;
		regReq = '0;
	endtask : regRead

	task automatic checkReg(input logic [`ADDR_W-1:0] a, input logic [15:0] mask, input logic [15:0] exp);
		logic [15:0] d;
		regRead(a, d);
		checkVal("register", exp, d & mask);
	endtask : checkReg

	// observable conditions used by the waiting tasks
	function automatic logic probe(input int sel);
		case (sel)
			0: return comparatorThreshold === 8'h40;
			1: return comparatorThreshold === 8'h30;
			2: return boostSwitchDriver === 1'b1;
			3: return gateDriversOff === 1'b0;
			4: return gateDriversOff === 1'b1;
			5: return interruptRequestPinN === 1'b0;
			default: return interruptRequestPinN === 1'b1;
		endcase
	endfunction : probe

	task automatic waitUntil(input int sel, input int lim);
		int k;
		k = 0;
		while (!probe(sel) && k < lim) begin
			@(negedge clock);
			k++;
		end
		checkVal($sformatf("condition %0d reached", sel), 16'h0001, {15'h0, probe(sel)});
	endtask : waitUntil

	task automatic noneFor(input int sel, input int cycles);
		int hits;
		hits = 0;
		repeat (cycles) begin
			@(negedge clock);
			if (probe(sel)) hits++;
		end
		checkVal($sformatf("condition %0d absent", sel), 16'h0000, hits[15:0]);
	endtask : noneFor

	task automatic supplyDip(input int cycles);
		@(negedge clock);
		supplyCompLow = 1'b1;
		repeat (cycles) @(negedge clock);
		supplyCompLow = 1'b0;
	endtask : supplyDip

	initial begin
		repeat (12) @(negedge clock);
		checkVal("drivers off in reset", 16'h0001, {15'h0, gateDriversOff});
		checkVal("switch in reset", 16'h0000, {15'h0, boostSwitchDriver});
		checkVal("irq pin in reset", 16'h0001, {15'h0, interruptRequestPinN});
		nrst = 1'b1;
		// release needs FILT+1 clean edges; a one-cycle dip restarts the count
		noneFor(3, FILT - 1);
		waitUntil(3, 4);
		supplyDip(1);
		waitUntil(4, 3);
		repeat (5) @(negedge clock);
		supplyDip(1);
		noneFor(3, FILT - 1);
		waitUntil(3, 5);
		$display("test supply filter done");
		checkReg(`OFS_BOOST_VOLTAGE_DAC, 16'hFFFF, `RST_BOOST_VOLTAGE_DAC);
		checkReg(`OFS_BOOST_FILTER_CFG, 16'hFFFF, `RST_BOOST_FILTER_CFG);
		checkReg(`OFS_DRIVER_CONFIGURATION, 16'hFFFF, 16'h0001);
		checkReg(`OFS_CURRENT_LEVELS, 16'hFFFF, `RST_CURRENT_LEVELS);
		checkReg(`OFS_FIXED_TIMING, 16'hFFFF, `RST_FIXED_TIMING);
		checkReg(9'h100, 16'hFFFF, 16'h0000);
		$display("test register reset done");
		// sticky flags from power-up clear on read; writes to the flags are refused
		regRead(`OFS_DRIVER_FAULT_FLAGS, rd);
		regWrite(`OFS_DRIVER_FAULT_FLAGS, 16'hFFFF);
		checkReg(`OFS_DRIVER_FAULT_FLAGS, 16'h0007, 16'h0000);
		regWrite(`OFS_DRIVER_CONFIGURATION, 16'h0003);
		supplyDip(3);
		waitUntil(5, 6);
		checkReg(`OFS_DRIVER_FAULT_FLAGS, 16'h0005, 16'h0005);
		waitUntil(3, FILT + 4);
		regRead(`OFS_DRIVER_FAULT_FLAGS, rd);
		regRead(`OFS_DRIVER_FAULT_FLAGS, rd);
		waitUntil(6, 3);
		regWrite(`OFS_DRIVER_CONFIGURATION, 16'h0001);
		supplyDip(3);
		noneFor(5, 8);
		waitUntil(3, FILT + 4);
		regRead(`OFS_DRIVER_FAULT_FLAGS, rd);
		$display("test supply interrupt done");
		regWrite(`OFS_CURRENT_LEVELS, 16'h7CC2);
		checkReg(`OFS_CURRENT_LEVELS, 16'hFFFF, 16'h7CC2);
		checkVal("low level", 16'h0002, {11'h0, currentLowLevel});
		checkVal("high level", 16'h0006, {11'h0, currentHighLevel});
		checkVal("negative level", 16'h001F, {11'h0, negativeCurrentLevel});
		regWrite(`OFS_BOOST_VOLTAGE_DAC, 16'h3040);
		regWrite(`OFS_BOOST_FILTER_CFG, 16'h0004);
		checkReg(`OFS_BOOST_FILTER_CFG, 16'hFFFF, 16'h0004);
		// variable-frequency burst with the plant answering
		regWrite(`OFS_DRIVER_CONFIGURATION, 16'h0009);
		waitUntil(0, 300);
		waitUntil(2, 300);
		inject = 1'b1;
		repeat (3) @(negedge clock);
		noneFor(2, 20);
		inject = 1'b0;
		negOver = 1'b1;
		@(negedge clock);
		negOver = 1'b0;
		waitUntil(1, 3000);
		checkVal("switch after burst", 16'h0000, {15'h0, boostSwitchDriver});
		checkReg(`OFS_DRIVER_FAULT_FLAGS, 16'h000A, 16'h0002);
		$display("test variable burst done");
		// each of the five supply status conditions in turn stops an active switch
		regWrite(`OFS_DRIVER_CONFIGURATION, 16'h0008);
		for (int k = 0; k < 5; k++) begin
			waitUntil(2, 800);
			supplyStatus = supplyStatus ^ (5'b10000 >> k);
			repeat (2) @(negedge clock);
			noneFor(2, 30);
			supplyStatus = 5'b10111;
		end
		regWrite(`OFS_DRIVER_CONFIGURATION, 16'h0009);
		supplyStatus.driverEnablePin = 1'b0;
		waitUntil(2, 800);
		supplyStatus.driverEnablePin = 1'b1;
		$display("test switch gating done");
		// fast assertion type for the rest of the run; rising output ends bursts at once
		regWrite(`OFS_BOOST_FILTER_CFG, 16'h8004);
		checkReg(`OFS_BOOST_FILTER_CFG, 16'hFFFF, 16'h8004);
		// fixed frequency keeps switching through injection, 9 cycles on
		regWrite(`OFS_DRIVER_CONFIGURATION, 16'h000D);
		inject = 1'b1;
		waitUntil(2, 800);
		waitUntil(3, 0);
		@(negedge clock);
		while (boostSwitchDriver === 1'b1) @(negedge clock);
		@(negedge clock);
		while (boostSwitchDriver !== 1'b1) @(negedge clock);
		n = 0;
		while (boostSwitchDriver === 1'b1 && n < 40) begin
			@(negedge clock);
			n++;
		end
		checkVal("fixed on time", 16'h0009, n[15:0]);
		regRead(`OFS_DRIVER_FAULT_FLAGS, rd);
		negOver = 1'b1;
		repeat (3) @(negedge clock);
		negOver = 1'b0;
		checkReg(`OFS_DRIVER_FAULT_FLAGS, 16'h0002, 16'h0000);
		waitUntil(1, 3000);
		checkVal("switch after fixed burst", 16'h0000, {15'h0, boostSwitchDriver});
		inject = 1'b0;
		$display("test fixed burst done");
		tally_and_finish();
	end
endmodule : boost_supply_supervisor_test
`default_nettype wire
